// *** rtl/hpg_map.svh ***
// register map, field positions and counts of the host port pin block
// Operation
// - reset or soft reset bit clears fifo pointers, contents and fifo logic
// - active host cycle at reset: ready high until cycle ends, then low
// - during reset with strobe high: fifos held in reset, ready held low
// - first variant, 8-bit muxed: select, strobe, data 7:0 are local gpio
// - first variant, not 8-bit muxed: those pins go to system io
// - access selects and interrupt pin are local gpio in every mode
// - strobes, chip select, read/write are gpio only while port disabled
// - ready output and port enable input are never gpio
// - second variant 8-bit muxed: select, strobe, data 7:0 local gpio
// - second variant 16-bit muxed: address, data 15:0 local, rest system
// - each enable bit picks host function or gpio for its pins
// - one direction bit per gpio pin: input or output
// - data bit reads sampled input level or drives output level
// - address strobe input may be interrupt source with inversion
`ifndef HPG_MAP_SVH
`define HPG_MAP_SVH
`define HPG_OFS_CTRL 12'h000
`define HPG_OFS_EN 12'h004
`define HPG_OFS_DIR1 12'h008
`define HPG_OFS_DIR2 12'h00c
`define HPG_OFS_DIR3 12'h010
`define HPG_OFS_DAT1 12'h014
`define HPG_OFS_DAT2 12'h018
`define HPG_OFS_DAT3 12'h01c
`define HPG_OFS_INT1 12'h020
`define HPG_OFS_INT2 12'h024
`define HPG_OFS_STAT 12'h028
`define HPG_OFS_MASK 12'h02c
`define HPG_NPIN 41
`define HPG_NCTL 9
`define HPG_D_LSB 9
`define HPG_A_LSB 25
`define HPG_P_AS 8
`define HPG_EN_W 12
`define HPG_EN_DLO 9
`define HPG_EN_DHI 10
`define HPG_EN_ADR 11
`define HPG_ST_AS 0
`define HPG_ST_SR 1
`define HPG_FIFO_RST_CYC 4'h4
`define HPG_RESP_OK 2'b00
`define HPG_RESP_ERR 2'b10
`endif

// *** rtl/hpg_pkg.sv ***
// types of the host port pin block
`include "hpg_map.svh"
package hpg_pkg;
   typedef enum logic [1:0] {HPG_RUN, HPG_FINISH, HPG_HOLD} hpg_rst_st_t;
   typedef struct packed {
      hpg_rst_st_t st;
      logic sr_pend;
      logic [3:0] cnt;
      logic ready;
      logic fifo_rst;
      logic [`HPG_EN_W-1:0] en;
      logic [`HPG_NPIN-1:0] dir;
      logic [`HPG_NPIN-1:0] dout;
      logic [`HPG_NPIN-1:0] s1;
      logic [`HPG_NPIN-1:0] s2;
      logic as_prev;
      logic irq_en;
      logic irq_inv;
      logic [1:0] stat;
      logic [1:0] mask;
      logic irq;
      logic [`HPG_NPIN-1:0] sel;
      logic [`HPG_NPIN-1:0] oe_n;
      logic [`HPG_NPIN-1:0] pout;
      logic sys_io;
      logic aw_ok;
      logic [11:0] awaddr;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } hpg_state_t;
endpackage

// *** rtl/hpg_top.sv ***
// host port pin gpio, reset hold-off and axi4-lite register slave
`include "hpg_map.svh"
module hpg_top
   import hpg_pkg::*;
#(
   parameter int FIFO_RST_CYC = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic variant_second,
   input wire logic mux8_mode,
   input wire logic mux16_mode,
   input wire logic port_enable_in,
   input wire logic internal_host_strobe,
   input wire logic fifo_ready_in,
   output logic host_ready_out,
   output logic fifo_reset_out,
   output logic system_level_io,
   output logic irq_out,
   input wire logic [`HPG_NPIN-1:0] pin_in,
   output logic [`HPG_NPIN-1:0] pin_out,
   output logic [`HPG_NPIN-1:0] pin_oe_n,
   output logic [`HPG_NPIN-1:0] pin_gpio_sel
);

   hpg_state_t q;
   hpg_state_t d;

   // byte-lane merge, used by the enable, direction and data registers
   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // widen enable bits to one bit per pin
   function automatic logic [`HPG_NPIN-1:0] en_pins(input logic [`HPG_EN_W-1:0] e);
      logic [`HPG_NPIN-1:0] r;
      r = '0;
      r[`HPG_NCTL-1:0] = e[`HPG_NCTL-1:0];
      r[`HPG_D_LSB +: 8] = {8{e[`HPG_EN_DLO]}};
      r[`HPG_D_LSB+8 +: 8] = {8{e[`HPG_EN_DHI]}};
      r[`HPG_A_LSB +: 16] = {16{e[`HPG_EN_ADR]}};
      return r;
   endfunction

   logic [`HPG_NPIN-1:0] avail;
   logic low_grp;
   logic wide_grp;
   logic [`HPG_NPIN-1:0] level;
   logic as_now;
   logic as_edge;
   logic do_wr;
   logic do_rd;
   logic [31:0] rd_val;
   logic rd_hit;
   logic wr_hit;
   logic [1:0] st_set;
   logic [1:0] st_clr;
   logic [31:0] reg_w;

   always_comb begin
      d = q;
      // pin ownership; ready and port enable have no slot at all
      low_grp = mux8_mode;
      wide_grp = variant_second & mux16_mode & ~mux8_mode;
      avail = '0;
      avail[2:0] = 3'h7;
      avail[6:3] = {4{~port_enable_in}};
      avail[`HPG_NCTL-1:7] = {2{low_grp}};
      avail[`HPG_D_LSB +: 8] = {8{low_grp | wide_grp}};
      avail[`HPG_D_LSB+8 +: 8] = {8{wide_grp}};
      avail[`HPG_A_LSB +: 16] = {16{wide_grp}};
      // select and strobe move to system io, and low data too in the first variant
      d.sys_io = (~variant_second & ~mux8_mode) | wide_grp;
      d.sel = en_pins(q.en) & avail;
      d.oe_n = ~(d.sel & q.dir);
      d.pout = q.dout;

      // two-stage sync; s1 feeds only s2
      d.s1 = pin_in;
      d.s2 = q.s1;
      level = (q.sel & q.dir & q.dout) | (q.sel & ~q.dir & q.s2) | (~q.sel & q.s2);
      as_now = q.s2[`HPG_P_AS] ^ q.irq_inv;
      d.as_prev = as_now;
      as_edge = as_now & ~q.as_prev & q.irq_en & q.sel[`HPG_P_AS] & ~q.dir[`HPG_P_AS];

      // reset hold-off sequencer
      st_set = '0;
      st_set[`HPG_ST_AS] = as_edge;
      d.cnt = '0;
      unique case (q.st)
         HPG_RUN: begin
            d.ready = fifo_ready_in;
            d.fifo_rst = 1'b0;
            if (q.sr_pend) begin
               if (!internal_host_strobe) begin
                  d.st = HPG_FINISH;
                  d.ready = 1'b1;
               end else begin
                  d.st = HPG_HOLD;
                  d.ready = 1'b0;
                  d.fifo_rst = 1'b1;
               end
            end
         end
         HPG_FINISH: begin
            // let the running host cycle end cleanly
            d.ready = 1'b1;
            d.fifo_rst = 1'b0;
            if (internal_host_strobe) begin
               d.st = HPG_HOLD;
               d.ready = 1'b0;
               d.fifo_rst = 1'b1;
            end
         end
         HPG_HOLD: begin
            d.ready = 1'b0;
            d.fifo_rst = 1'b1;
            d.cnt = q.cnt + 4'h1;
            if (!internal_host_strobe) begin
               // new cycle during hold: still held off
               d.cnt = q.cnt;
            end else if (q.cnt >= FIFO_RST_CYC[3:0] - 4'h1) begin
               d.st = HPG_RUN;
               d.sr_pend = 1'b0;
               d.fifo_rst = 1'b0;
               st_set[`HPG_ST_SR] = 1'b1;
            end
         end
      endcase

      // axi4-lite write side: address and data in either order
      do_wr = q.aw_ok & q.w_ok & ~q.bvalid;
      if (s_axi_awvalid && !q.aw_ok) begin
         d.aw_ok = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_ok) begin
         d.w_ok = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      wr_hit = 1'b1;
      reg_w = 32'h0;
      if (do_wr) begin
         d.aw_ok = 1'b0;
         d.w_ok = 1'b0;
         d.bvalid = 1'b1;
         unique case ({q.awaddr[11:2], 2'b00})
            `HPG_OFS_CTRL: begin
               // writing 0 cannot cancel a running reset
               if (q.wstrb[0] && q.wdata[0]) begin
                  d.sr_pend = 1'b1;
               end
            end
            `HPG_OFS_EN: begin
               reg_w = wmerge({20'h0, q.en}, q.wdata, q.wstrb);
               d.en = reg_w[`HPG_EN_W-1:0];
            end
            `HPG_OFS_DIR1: begin
               reg_w = wmerge({23'h0, q.dir[`HPG_NCTL-1:0]}, q.wdata, q.wstrb);
               d.dir[`HPG_NCTL-1:0] = reg_w[`HPG_NCTL-1:0];
            end
            `HPG_OFS_DIR2: begin
               reg_w = wmerge({16'h0, q.dir[`HPG_D_LSB +: 16]}, q.wdata, q.wstrb);
               d.dir[`HPG_D_LSB +: 16] = reg_w[15:0];
            end
            `HPG_OFS_DIR3: begin
               reg_w = wmerge({16'h0, q.dir[`HPG_A_LSB +: 16]}, q.wdata, q.wstrb);
               d.dir[`HPG_A_LSB +: 16] = reg_w[15:0];
            end
            `HPG_OFS_DAT1: begin
               reg_w = wmerge({23'h0, q.dout[`HPG_NCTL-1:0]}, q.wdata, q.wstrb);
               d.dout[`HPG_NCTL-1:0] = reg_w[`HPG_NCTL-1:0];
            end
            `HPG_OFS_DAT2: begin
               reg_w = wmerge({16'h0, q.dout[`HPG_D_LSB +: 16]}, q.wdata, q.wstrb);
               d.dout[`HPG_D_LSB +: 16] = reg_w[15:0];
            end
            `HPG_OFS_DAT3: begin
               reg_w = wmerge({16'h0, q.dout[`HPG_A_LSB +: 16]}, q.wdata, q.wstrb);
               d.dout[`HPG_A_LSB +: 16] = reg_w[15:0];
            end
            `HPG_OFS_INT1: begin
               if (q.wstrb[0]) begin
                  d.irq_en = q.wdata[0];
               end
            end
            `HPG_OFS_INT2: begin
               if (q.wstrb[0]) begin
                  d.irq_inv = q.wdata[0];
               end
            end
            `HPG_OFS_MASK: begin
               if (q.wstrb[0]) begin
                  d.mask = q.wdata[1:0];
               end
            end
            `HPG_OFS_STAT: begin
               // status is cleared by reading only
            end
            default: begin
               wr_hit = 1'b0;
            end
         endcase
         d.bresp = wr_hit ? `HPG_RESP_OK : `HPG_RESP_ERR;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end

      // read side: arready is the one-cycle take pulse
      do_rd = s_axi_arvalid & ~q.rvalid;
      rd_hit = 1'b1;
      rd_val = 32'h0;
      st_clr = '0;
      unique case ({s_axi_araddr[11:2], 2'b00})
         `HPG_OFS_CTRL: rd_val = {29'h0, q.fifo_rst, q.ready, q.sr_pend};
         `HPG_OFS_EN: rd_val = {20'h0, q.en};
         `HPG_OFS_DIR1: rd_val = {23'h0, q.dir[`HPG_NCTL-1:0]};
         `HPG_OFS_DIR2: rd_val = {16'h0, q.dir[`HPG_D_LSB +: 16]};
         `HPG_OFS_DIR3: rd_val = {16'h0, q.dir[`HPG_A_LSB +: 16]};
         `HPG_OFS_DAT1: rd_val = {23'h0, level[`HPG_NCTL-1:0]};
         `HPG_OFS_DAT2: rd_val = {16'h0, level[`HPG_D_LSB +: 16]};
         `HPG_OFS_DAT3: rd_val = {16'h0, level[`HPG_A_LSB +: 16]};
         `HPG_OFS_INT1: rd_val = {31'h0, q.irq_en};
         `HPG_OFS_INT2: rd_val = {31'h0, q.irq_inv};
         `HPG_OFS_STAT: begin
            rd_val = {30'h0, q.stat};
            st_clr = do_rd ? 2'b11 : 2'b00;
         end
         `HPG_OFS_MASK: rd_val = {30'h0, q.mask};
         default: rd_hit = 1'b0;
      endcase
      if (do_rd) begin
         d.rvalid = 1'b1;
         d.rdata = rd_val;
         d.rresp = rd_hit ? `HPG_RESP_OK : `HPG_RESP_ERR;
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end

      // set wins over the read-clear in the same cycle
      d.stat = (q.stat & ~st_clr) | st_set;
      d.irq = |(d.stat & q.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         // hardware reset: fifos held, host cycle may still finish
         q.st <= HPG_FINISH;
         q.fifo_rst <= 1'b1;
         q.oe_n <= '1;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready = s_axi_awvalid & ~q.aw_ok;
   assign s_axi_wready = s_axi_wvalid & ~q.w_ok;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = s_axi_arvalid & ~q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;
   assign host_ready_out = q.ready;
   assign fifo_reset_out = q.fifo_rst;
   assign system_level_io = q.sys_io;
   assign irq_out = q.irq;
   assign pin_out = q.pout;
   assign pin_oe_n = q.oe_n;
   assign pin_gpio_sel = q.sel;

endmodule

// *** testbench/hpg_monitor.sv ***
// assertion checker of the host port pin block, bound to its top
`include "hpg_map.svh"
module hpg_monitor #(
   parameter int FIFO_RST_CYC = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_arready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic variant_second,
   input wire logic mux8_mode,
   input wire logic mux16_mode,
   input wire logic port_enable_in,
   input wire logic internal_host_strobe,
   input wire logic host_ready_out,
   input wire logic fifo_reset_out,
   input wire logic system_level_io,
   input wire logic [`HPG_NPIN-1:0] pin_oe_n,
   input wire logic [`HPG_NPIN-1:0] pin_gpio_sel
);
   timeunit 1ns;
   timeprecision 1ps;
   // margin covers the finish state and the output register
   localparam int HMAX = FIFO_RST_CYC + 4;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_rst_state: assert property ($rose(aresetn) |-> fifo_reset_out && !host_ready_out
      && !s_axi_bvalid && &pin_oe_n && pin_gpio_sel == '0) else $error("bad state after reset");
   a_hold_len: assert property (fifo_reset_out && internal_host_strobe |->
      ##[0:HMAX] (!fifo_reset_out || !internal_host_strobe)) else $error("fifo reset too long");
   a_fin_ready: assert property (fifo_reset_out |-> !host_ready_out)
      else $error("ready high while fifos held");
   a_hold_ready: assert property ((fifo_reset_out && internal_host_strobe)[*2]
      |-> !host_ready_out) else $error("ready not held off");
   a_ctl_gate: assert property (port_enable_in[*3] |-> pin_gpio_sel[6:3] == 4'h0)
      else $error("strobe pins free while port enabled");
   a_sys_hand: assert property ((!variant_second && !mux8_mode)[*3]
      |-> system_level_io && pin_gpio_sel[16:7] == 10'h000) else $error("pins not handed over");
   a_hi_block: assert property ((!variant_second || !mux16_mode || mux8_mode)[*3]
      |-> pin_gpio_sel[40:17] == 24'h000000) else $error("upper pins in gpio use");
   a_oe_sel: assert property ((~pin_oe_n & ~pin_gpio_sel) == '0)
      else $error("host function pin driven");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write response dropped");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
   c_finish: cover property (host_ready_out && !internal_host_strobe ##1 internal_host_strobe
      ##1 fifo_reset_out);
   c_sys: cover property (system_level_io);
   c_addr: cover property (pin_gpio_sel[40]);
endmodule
bind hpg_top hpg_monitor #(.FIFO_RST_CYC(FIFO_RST_CYC)) hpg_monitor_i (.aclk, .aresetn,
   .s_axi_arready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .variant_second,
   .mux8_mode, .mux16_mode, .port_enable_in, .internal_host_strobe, .host_ready_out,
   .fifo_reset_out, .system_level_io, .pin_oe_n, .pin_gpio_sel);

// *** testbench/hpg_host_model.sv ***
// behavioural external host: strobe cycles and pin levels
`include "hpg_map.svh"
module hpg_host_model (
   input wire logic aclk,
   input wire logic go,
   input wire logic host_ready_out,
   input wire logic [`HPG_NPIN-1:0] pin_out,
   input wire logic [`HPG_NPIN-1:0] pin_oe_n,
   input wire logic [`HPG_NPIN-1:0] ext,
   output logic internal_host_strobe,
   output logic [`HPG_NPIN-1:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // a driven pin reads back its own level, an idle one the outside source
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
   // a cycle only ends once ready is seen high
   initial internal_host_strobe = 1'b1;
   always @(posedge aclk) begin
      if (go && internal_host_strobe) begin
         internal_host_strobe <= 1'b0;
      end else if (!internal_host_strobe && host_ready_out) begin
         internal_host_strobe <= 1'b1;
      end
   end
endmodule

// *** testbench/hpg_top_bench.sv ***
// self-checking bench of the host port pin block
`include "hpg_map.svh"
module hpg_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, go;
   logic variant_second, mux8_mode, mux16_mode, port_enable_in, internal_host_strobe;
   logic fifo_ready_in, host_ready_out, fifo_reset_out, system_level_io, irq_out;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [`HPG_NPIN-1:0] pin_in, pin_out, pin_oe_n, pin_gpio_sel, ext;
   logic [3:0] cf [4] = '{4'h4, 4'hb, 4'h1, 4'hd};
   logic [40:0] es [4] = '{41'h1ffff, 41'h1fffffffe07, 41'h7, 41'h1ff87};
   int n_fail = 0, total_checks = 0, cyc = 0, n;
   hpg_top #(.FIFO_RST_CYC(4)) hpg_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .variant_second, .mux8_mode, .mux16_mode,
      .port_enable_in, .internal_host_strobe, .fifo_ready_in, .host_ready_out, .fifo_reset_out,
      .system_level_io, .irq_out, .pin_in, .pin_out, .pin_oe_n, .pin_gpio_sel);
   hpg_host_model hpg_host_model_i (.aclk, .go, .host_ready_out, .pin_out, .pin_oe_n, .ext,
      .internal_host_strobe, .pin_in);
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ceiling well above the hundred-odd cycles the tests need
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // handshakes are judged at the falling edge, where ready has settled
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic ta, tw, tb;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
   endtask
   task rdr(input logic [11:0] a);
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
   endtask
   task settle;
      repeat (4) @(negedge aclk);
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go, ext} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_bready, s_axi_rready, fifo_ready_in, s_axi_wstrb} = 7'h7f;
      {variant_second, mux8_mode, mux16_mode, port_enable_in} = cf[0];
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      for (n = 0; n < 50 && fifo_reset_out !== 1'b0; n++) @(negedge aclk);
      @(negedge aclk);
      chk(fifo_reset_out, 0);
      chk(host_ready_out, 1);
      $display("reset test done");
      @(posedge aclk);
      wr(`HPG_OFS_EN, 32'h00000fff);
      for (int i = 0; i < 4; i++) begin
         {variant_second, mux8_mode, mux16_mode, port_enable_in} <= cf[i];
         settle();
         chk(pin_gpio_sel, es[i]);
         chk(system_level_io, 4'b0110 >> i & 1);
         @(posedge aclk);
      end
      $display("pin map test done");
      {variant_second, mux8_mode, mux16_mode, port_enable_in} <= cf[0];
      ext[8:3] <= 6'b101101;
      wr(`HPG_OFS_DIR1, 32'h00000007);
      wr(`HPG_OFS_DAT1, 32'h00000005);
      settle();
      chk(pin_out[2:0], 3'b101);
      chk(pin_oe_n[8:0], 9'h1f8);
      @(posedge aclk);
      rdr(`HPG_OFS_DAT1);
      chk(rd[8:0], 9'h16d);
      $display("gpio test done");
      wr(`HPG_OFS_INT1, 32'h00000001);
      wr(`HPG_OFS_MASK, 32'h00000001);
      ext[8] <= 1'b0;
      settle();
      @(posedge aclk);
      rdr(`HPG_OFS_STAT);
      ext[8] <= 1'b1;
      repeat (6) @(negedge aclk);
      chk(irq_out, 1);
      @(posedge aclk);
      rdr(`HPG_OFS_STAT);
      chk(rd[0], 1);
      settle();
      chk(irq_out, 0);
      @(posedge aclk);
      wr(`HPG_OFS_MASK, 32'h00000000);
      wr(`HPG_OFS_INT2, 32'h00000001);
      settle();
      @(posedge aclk);
      rdr(`HPG_OFS_STAT);
      ext[8] <= 1'b0;
      repeat (6) @(negedge aclk);
      chk(irq_out, 0);
      @(posedge aclk);
      rdr(`HPG_OFS_STAT);
      chk(rd[0], 1);
      wr(12'h0f0, 32'h00000001);
      chk(rs, `HPG_RESP_ERR);
      rdr(12'h0f0);
      chk({rs, rd}, {`HPG_RESP_ERR, 32'h00000000});
      $display("interrupt test done");
      fifo_ready_in <= 1'b0;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      settle();
      chk(host_ready_out, 0);
      @(posedge aclk);
      wr(`HPG_OFS_CTRL, 32'h00000001);
      for (n = 0; n < 50 && host_ready_out !== 1'b1; n++) @(negedge aclk);
      chk(host_ready_out, 1);
      for (n = 0; n < 50 && internal_host_strobe !== 1'b1; n++) @(negedge aclk);
      @(negedge aclk);
      chk({host_ready_out, fifo_reset_out}, 2'b01);
      for (n = 0; n < 50 && fifo_reset_out !== 1'b0; n++) @(negedge aclk);
      @(posedge aclk);
      rdr(`HPG_OFS_CTRL);
      chk(rd[0], 0);
      rdr(`HPG_OFS_STAT);
      chk(rd[1], 1);
      $display("soft reset test done");
      test_done();
   end
endmodule
